// file: design/chan_ctrl.v
// one channel's periodic-collection and channel control register group
// Notes on behaviour
// (RL1) each slave buffer holds a 20-bit word, top nibble is the source id
// (RL2) buffer fault bit 7 set on checksum, symbol or receiver mismatch error
// (RL3) buffer bit 5 set while fresh slave data waits
// (RL4) manual broadcast bit sends one broadcast read if enabled and auto off
// (RL5) auto broadcast bit sends a broadcast read every 500 us
// (RL6) writes to auto bit ignored while collection enable is 0
// (RL7) collection enable blocks command traffic and configuration changes
// (RL8) collection enable clears only through the channel clear register
// (RL9) writing 0xff to channel clear resets every channel register
// (RL10) broadcast delayed by delay field times 0.5 us from request
// (RL11) supply test bit forces monitor low so the supply-low flag sets
// (RL12) control bit 2 enables or disables channel when conditions hold
// (RL13) buffer check mode entered only when both check bits written together
// (RL14) buffer check write discards enable and discovery count of same frame
// (RL15) discovery count write sends that many pulses if conditions hold
// (RL16) status bit 7 set on pll unlock
// (RL17) status bit 6 set when reference clock out of range
// (RL18) status bit 5 analogue ground open, bit 4 digital ground open
// (RL19) status bit 3 set on sustained overcurrent shutdown
// (RL20) status bit 2 set on thermal shutdown
// (RL21) status bit 0 set on supply low, mirrored in every buffer
// (RL22) status flags stay set until host writes 0 to them
// (RL23) writing 1 leaves a flag; a persisting condition sets it again
`include "chan_ctrl_regs.vh"
module chan_ctrl #(
  parameter [6:0] CHAN_BASE = 7'h00,
  parameter AUTO_PERIOD_CYC = `AUTO_PERIOD_CYC
) (
  input wire i_clk,             // 100 MHz system clock
  input wire i_rst_n,           // async reset, active low
  input wire i_ce,              // clock enable, freezes state when low
  input wire i_sck,             // serial clock pin
  input wire i_cs_n,            // serial chip select pin, active low
  input wire i_mosi,            // serial data in pin
  output reg o_miso,            // serial data out
  output wire o_miso_oe,        // serial data out enable
  input wire i_rx_valid,        // received slave word strobe
  input wire [1:0] i_rx_slot,   // slave address of received word
  input wire [19:0] i_rx_data,  // received word
  input wire i_rx_fault,        // checksum, symbol or mismatch error
  input wire i_chan_cond,       // channel enable conditions met
  input wire i_disc_cond,       // discovery conditions met
  input wire i_pll_unlock,      // pll unlocked
  input wire i_ref_clk_bad,     // reference clock out of range
  input wire i_agnd_open,       // analogue ground open
  input wire i_dgnd_open,       // digital ground open
  input wire i_overcurrent,     // current limiter timed out
  input wire i_thermal,         // driver thermal limit
  input wire i_supply_low,      // bus supply monitor below threshold
  output reg o_broadcast_send,  // broadcast read command pulse
  output wire o_collect_mode,   // periodic collection mode active
  output wire o_chan_en,        // channel enable
  output wire o_monitor_force,  // supply monitor input forced low
  output reg o_bcm_enter,       // buffer check mode entry pulse
  output reg o_disc_start,      // discovery pulses start pulse
  output wire [2:0] o_disc_count // discovery pulse count
);
  // ----------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------
  // reset released through two stages, asserted at once
  reg [1:0] rst_sync_reg;
  wire rst_n = rst_sync_reg[1];
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  reg [2:0] sck_reg;
  reg [2:0] cs_reg;
  reg [1:0] mosi_reg;
  reg [6:0] flt_meta_reg;
  // fault levels pass two stages like the serial pins
  reg [6:0] flt_reg;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_reg <= 3'b000;
      cs_reg <= 3'b111;
      mosi_reg <= 2'b00;
      flt_meta_reg <= 7'h00;
      flt_reg <= 7'h00;
    end else if (i_ce) begin
      sck_reg <= {sck_reg[1:0], i_sck};
      cs_reg <= {cs_reg[1:0], i_cs_n};
      mosi_reg <= {mosi_reg[0], i_mosi};
      flt_meta_reg <= {i_pll_unlock, i_ref_clk_bad, i_agnd_open, i_dgnd_open,
                       i_overcurrent, i_thermal, i_supply_low};
      flt_reg <= flt_meta_reg;
    end
  end
  wire sck_rise = sck_reg[1] & ~sck_reg[2];
  wire sck_fall = ~sck_reg[1] & sck_reg[2];
  wire cs_act = ~cs_reg[1];
  wire frame_end = cs_reg[1] & ~cs_reg[2];

  // ----------------------------------------
  // serial frame shifter
  // ----------------------------------------
  reg [5:0] bit_cnt_reg;
  reg [31:0] rx_sh_reg;
  reg [22:0] tx_sh_reg;
  reg overrun_reg;
  reg [23:0] rd_word;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= 6'd0;
      overrun_reg <= 1'b0;
      rx_sh_reg <= 32'h00000000;
      tx_sh_reg <= 23'h000000;
      o_miso <= 1'b0;
    end else if (i_ce) begin
      if (!cs_act) begin
        bit_cnt_reg <= 6'd0;
        overrun_reg <= 1'b0;
        o_miso <= 1'b0;
      end else begin
        if (sck_rise && bit_cnt_reg != 6'd32) begin
          rx_sh_reg <= {rx_sh_reg[30:0], mosi_reg[1]};
          bit_cnt_reg <= bit_cnt_reg + 6'd1;
        end
        if (sck_rise && bit_cnt_reg == 6'd32) begin
          overrun_reg <= 1'b1; // frames longer than 32 bits are dropped
        end
        if (sck_fall) begin
          if (bit_cnt_reg == 6'd8) begin
            {o_miso, tx_sh_reg} <= rd_word;
          end else begin
            {o_miso, tx_sh_reg} <= {tx_sh_reg, 1'b0};
          end
        end
      end
    end
  end
  // driver enabled for the whole selected frame
  assign o_miso_oe = cs_act;

  // address byte names the read target, full frame the write target
  wire [6:0] addr = (bit_cnt_reg == 6'd8) ? rx_sh_reg[6:0] : rx_sh_reg[30:24];
  wire [6:0] rel = addr - CHAN_BASE;
  wire frame_ok = frame_end & (bit_cnt_reg == 6'd32) & ~overrun_reg;
  wire wr_frame = frame_ok & rx_sh_reg[31];
  wire rd_frame = frame_ok & ~rx_sh_reg[31];
  wire [7:0] wb2 = rx_sh_reg[23:16];
  wire [7:0] wb3 = rx_sh_reg[15:8];
  wire [7:0] wb4 = rx_sh_reg[7:0];
  wire is_slot = (rel == `OFS_SLAVE_WORD0) | (rel == `OFS_SLAVE_WORD1) |
                 (rel == `OFS_SLAVE_WORD2) | (rel == `OFS_SLAVE_WORD3);
  wire [1:0] slot = rel[2:1] - 2'd1;
  wire wr_pctrl = wr_frame & (rel == `OFS_PERIODIC_CTRL);
  wire wr_cctrl = wr_frame & (rel == `OFS_CHANNEL_CTRL);
  wire chan_clear = wr_frame & (rel == `OFS_CHANNEL_CLEAR) &
                    (wb2 == `CHANNEL_CLEAR_CODE); // RL9

  // ----------------------------------------
  // receive buffers
  // ----------------------------------------
  reg [3:0] rne_reg;
  reg [3:0] loaded_reg;
  wire [20:0] mem_rdata;
  slave_word_mem #(
    .WIDTH(21),
    .DEPTH(4),
    .AW(2)
  ) u_mem (
    .i_clk(i_clk),
    .i_ce(i_ce),
    .i_we(i_rx_valid),
    .i_waddr(i_rx_slot),
    .i_wdata({i_rx_fault, i_rx_data}), // RL1 RL2
    .i_raddr(slot),
    .o_rdata(mem_rdata)
  );

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rne_reg <= 4'h0;
      loaded_reg <= 4'h0;
    end else if (i_ce) begin
      if (chan_clear) begin
        rne_reg <= 4'h0;
        loaded_reg <= 4'h0;
      end else begin
        if (rd_frame && is_slot) begin
          rne_reg[slot] <= 1'b0;
        end
        if (i_rx_valid) begin
          rne_reg[i_rx_slot] <= 1'b1; // RL3
          loaded_reg[i_rx_slot] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  reg [7:0] pctrl_reg;
  reg [7:0] dly_reg;
  reg [7:0] cctrl_reg;
  reg [7:0] dpc_reg;
  reg [7:0] stat_reg;
  reg manual_req_reg;
  wire collect_en = pctrl_reg[`BIT_PERIODIC_ENABLE];
  wire auto_en = pctrl_reg[`BIT_AUTO_BROADCAST];
  wire bck_both = (wb2[1:0] == 2'b11);
  wire [7:0] flt_now = {flt_reg[6:1], 1'b0,
                        flt_reg[0] | cctrl_reg[`BIT_SUPPLY_TEST]}; // RL11
  wire [7:0] flt_in = {flt_now[7:2], 1'b0, flt_now[0]};

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pctrl_reg <= `RST_PERIODIC_CTRL;
      dly_reg <= `RST_DELAY;
      cctrl_reg <= `RST_CHANNEL_CTRL;
      dpc_reg <= `RST_DISC_COUNT;
      stat_reg <= `RST_STATUS;
      manual_req_reg <= 1'b0;
      o_bcm_enter <= 1'b0;
      o_disc_start <= 1'b0;
    end else if (i_ce) begin
      manual_req_reg <= 1'b0;
      o_bcm_enter <= 1'b0;
      o_disc_start <= 1'b0;
      if (chan_clear) begin
        pctrl_reg <= `RST_PERIODIC_CTRL; // RL8 RL9
        dly_reg <= `RST_DELAY;
        cctrl_reg <= `RST_CHANNEL_CTRL;
        dpc_reg <= `RST_DISC_COUNT;
        stat_reg <= `RST_STATUS;
      end else begin
        if (wr_pctrl) begin
          if (wb2[`BIT_PERIODIC_ENABLE]) begin
            pctrl_reg[`BIT_PERIODIC_ENABLE] <= 1'b1; // RL7 RL8
          end
          if (collect_en) begin
            pctrl_reg[`BIT_AUTO_BROADCAST] <= wb2[`BIT_AUTO_BROADCAST]; // RL6
          end
          if (wb2[`BIT_MANUAL_BROADCAST] && collect_en && !auto_en) begin
            manual_req_reg <= 1'b1; // RL4
          end
          if (!collect_en) begin
            dly_reg <= wb3; // RL7
          end
        end
        if (wr_cctrl && !collect_en) begin // RL7
          cctrl_reg[`BIT_SUPPLY_TEST] <= wb2[`BIT_SUPPLY_TEST];
          if (bck_both) begin
            o_bcm_enter <= 1'b1; // RL13 RL14
          end else begin
            if (i_chan_cond) begin
              cctrl_reg[`BIT_CHANNEL_EN] <= wb2[`BIT_CHANNEL_EN]; // RL12
            end
            dpc_reg <= {5'h00, wb3[2:0]};
            if (i_disc_cond && wb3[2:0] != 3'd0) begin
              o_disc_start <= 1'b1; // RL15
            end
          end
        end
        // write 0 clears, write 1 keeps, a live fault wins over the clear
        // status clears stay accepted in collection mode
        if (wr_cctrl) begin
          stat_reg <= ((stat_reg & (wb4 | ~`STAT_WRITABLE_MASK)) | flt_in) &
                      `STAT_WRITABLE_MASK; // RL22 RL23
        end else begin
          stat_reg <= stat_reg | flt_in; // RL16 RL17 RL18 RL19 RL20 RL21
        end
      end
    end
  end
  assign o_collect_mode = collect_en;
  assign o_chan_en = cctrl_reg[`BIT_CHANNEL_EN];
  assign o_monitor_force = cctrl_reg[`BIT_SUPPLY_TEST];
  assign o_disc_count = dpc_reg[2:0];

  // ----------------------------------------
  // broadcast read timing
  // ----------------------------------------
  localparam [31:0] PERIOD_RELOAD = AUTO_PERIOD_CYC - 1;
  // period counter idles at zero so the first tick fires at once
  reg [16:0] period_cnt_reg;
  reg [15:0] dly_cnt_reg;
  reg dly_busy_reg;
  wire auto_tick = collect_en & auto_en & (period_cnt_reg == 17'd0);
  wire start_req = manual_req_reg | auto_tick;
  // a request arriving while a delay runs is dropped
  wire [31:0] dly_prod = dly_reg * `DELAY_STEP_CYC;
  wire [15:0] dly_load = dly_prod[15:0]; // RL10

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt_reg <= 17'd0;
      dly_cnt_reg <= 16'd0;
      dly_busy_reg <= 1'b0;
      o_broadcast_send <= 1'b0;
    end else if (i_ce) begin
      o_broadcast_send <= 1'b0;
      if (!(collect_en && auto_en) || chan_clear) begin
        period_cnt_reg <= 17'd0;
      end else if (auto_tick) begin
        period_cnt_reg <= PERIOD_RELOAD[16:0]; // RL5
      end else begin
        period_cnt_reg <= period_cnt_reg - 17'd1;
      end
      if (chan_clear) begin
        dly_busy_reg <= 1'b0;
      end else if (start_req && !dly_busy_reg) begin
        if (dly_load == 16'd0) begin
          o_broadcast_send <= 1'b1;
        end else begin
          dly_cnt_reg <= dly_load - 16'd1;
          dly_busy_reg <= 1'b1;
        end
      end else if (dly_busy_reg) begin
        if (dly_cnt_reg == 16'd0) begin
          dly_busy_reg <= 1'b0;
          o_broadcast_send <= 1'b1; // RL10
        end else begin
          dly_cnt_reg <= dly_cnt_reg - 16'd1;
        end
      end
    end
  end

  // ----------------------------------------
  // read data mux
  // ----------------------------------------
  // slot data reads zero until its first word arrives
  always @* begin
    rd_word = 24'h000000;
    if (is_slot) begin
      rd_word[23] = loaded_reg[slot] & mem_rdata[20]; // RL2
      rd_word[21] = rne_reg[slot]; // RL3
      rd_word[20] = stat_reg[`BIT_SUPPLY_LOW]; // RL21
      rd_word[19:0] = loaded_reg[slot] ? mem_rdata[19:0] : 20'h00000;
    end else if (rel == `OFS_PERIODIC_CTRL) begin
      rd_word = {pctrl_reg & 8'h06, dly_reg, 8'h00};
    end else if (rel == `OFS_CHANNEL_CTRL) begin
      rd_word = {cctrl_reg & 8'h0c, dpc_reg, stat_reg};
    end
  end
endmodule

// file: design/chan_ctrl_regs.vh
// register offsets, field positions, reset values and timing counts
`ifndef CHAN_CTRL_REGS_VH
`define CHAN_CTRL_REGS_VH
// ----------------------------------------
// offsets within one channel (channel 0 base)
// ----------------------------------------
`define OFS_SLAVE_WORD0 7'h02
`define OFS_SLAVE_WORD1 7'h04
`define OFS_SLAVE_WORD2 7'h06
`define OFS_SLAVE_WORD3 7'h08
`define OFS_PERIODIC_CTRL 7'h0a
`define OFS_CHANNEL_CTRL 7'h0b
`define OFS_CHANNEL_CLEAR 7'h0e
`define CHANNEL_CLEAR_CODE 8'hff
// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_MANUAL_BROADCAST 0
`define BIT_AUTO_BROADCAST 1
`define BIT_PERIODIC_ENABLE 2
`define BIT_SUPPLY_TEST 3
`define BIT_CHANNEL_EN 2
`define BIT_RX_FAULT 7
`define BIT_RX_NOT_EMPTY 5
`define BIT_RX_SUPPLY_LOW 4
`define BIT_PLL_UNLOCK 7
`define BIT_REF_CLK_RANGE 6
`define BIT_ANALOG_GND_OPEN 5
`define BIT_DIGITAL_GND_OPEN 4
`define BIT_OVERCURRENT 3
`define BIT_THERMAL 2
`define BIT_SUPPLY_LOW 0
`define STAT_WRITABLE_MASK 8'hfd
// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_PERIODIC_CTRL 8'h00
`define RST_DELAY 8'h00
`define RST_CHANNEL_CTRL 8'h00
`define RST_DISC_COUNT 8'h00
`define RST_STATUS 8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_FREQ_MHZ 100
`define DELAY_STEP_NS 500
`define DELAY_STEP_CYC ((`DELAY_STEP_NS * `CLK_FREQ_MHZ) / 1000)
`define AUTO_PERIOD_US 500
`define AUTO_PERIOD_CYC (`AUTO_PERIOD_US * `CLK_FREQ_MHZ)
`define FRAME_BITS 32
`endif

// file: design/slave_word_mem.v
// small memory holding one received word per slave address
module slave_word_mem #(
  parameter WIDTH = 21,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire i_clk,              // system clock
  input wire i_ce,               // clock enable
  input wire i_we,               // write strobe
  input wire [AW-1:0] i_waddr,   // write address
  input wire [WIDTH-1:0] i_wdata, // write data
  input wire [AW-1:0] i_raddr,   // read address
  output reg [WIDTH-1:0] o_rdata // registered read data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge i_clk) begin
    if (i_ce) begin
      if (i_we) begin
        mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
    end
  end
endmodule

// file: tb/chan_ctrl_sva.sv
// port checks for the channel control register group
module chan_ctrl_sva #(
  parameter AUTO_PERIOD_CYC = 50000
) (
  input wire i_clk,             // clock
  input wire i_rst_n,           // reset, active low
  input wire i_cs_n,            // chip select pin
  input wire i_disc_cond,       // discovery conditions
  input wire o_broadcast_send,  // broadcast pulse
  input wire o_collect_mode,    // collection mode
  input wire o_chan_en,         // channel enable
  input wire o_monitor_force,   // supply test
  input wire o_bcm_enter,       // buffer check pulse
  input wire o_disc_start,      // discovery pulse
  input wire [2:0] o_disc_count // discovery count
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_send_pulse; o_broadcast_send |=> !o_broadcast_send; endproperty
  a_send_pulse: assert property (p_send_pulse) else $error("send pulse too long");
  property p_send_mode; o_broadcast_send |-> o_collect_mode; endproperty
  a_send_mode: assert property (p_send_mode) else $error("send outside collection");
  property p_cfg_frozen;
    o_collect_mode && $past(o_collect_mode) |->
      $stable(o_chan_en) && $stable(o_disc_count) && $stable(o_monitor_force);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("config changed");
  property p_clear_all;
    $fell(o_collect_mode) |-> i_cs_n && !o_chan_en && !o_monitor_force && o_disc_count == 3'h0;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("collection left wrongly");
  property p_bcm_excl; o_bcm_enter |-> !o_disc_start && $stable(o_chan_en); endproperty
  a_bcm_excl: assert property (p_bcm_excl) else $error("check write not exclusive");
  property p_bcm_once; o_bcm_enter |=> (!o_bcm_enter) [*8]; endproperty
  a_bcm_once: assert property (p_bcm_once) else $error("check entry repeated");
  property p_disc_once; o_disc_start |=> (!o_disc_start) [*8]; endproperty
  a_disc_once: assert property (p_disc_once) else $error("discovery repeated");
  property p_disc_cond; o_disc_start |-> $past(i_disc_cond); endproperty
  a_disc_cond: assert property (p_disc_cond) else $error("discovery without cond");
endmodule

bind chan_ctrl chan_ctrl_sva #(.AUTO_PERIOD_CYC(AUTO_PERIOD_CYC)) chk_u (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_disc_cond(i_disc_cond),
  .o_broadcast_send(o_broadcast_send), .o_collect_mode(o_collect_mode),
  .o_chan_en(o_chan_en), .o_monitor_force(o_monitor_force), .o_bcm_enter(o_bcm_enter),
  .o_disc_start(o_disc_start), .o_disc_count(o_disc_count));

// file: tb/host_spi_model.sv
// host side serial master, 32 bit frames, mode 0
module host_spi_model (
  output logic o_sck,     // serial clock, idle low
  output logic o_cs_n,    // chip select, active low
  output logic o_mosi,    // data to device
  input wire logic i_miso // data from device
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  task automatic xfer(input logic [7:0] a, input logic [23:0] wd, output logic [23:0] rd);
    logic [31:0] sh;
    sh = {a, wd};
    rd = 24'h0;
    o_cs_n = 1'b0;
    #62.5;
    for (int i = 31; i >= 0; i--) begin
      o_mosi = sh[i];
      #62.5;
      o_sck = 1'b1;
      if (i < 24) rd[i] = i_miso;
      #62.5;
      o_sck = 1'b0;
    end
    #62.5;
    o_cs_n = 1'b1;
    // released line must not keep its last level
    o_mosi = ~o_mosi;
    #100;
  endtask
endmodule

// file: tb/chan_ctrl_tb.sv
// self-checking bench for the channel control register group
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module chan_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int AUTO_CYC = 200;
  localparam int STEP = 50;
  logic i_clk, i_rst_n, i_ce, i_rx_valid, i_rx_fault, i_chan_cond, i_disc_cond;
  logic [1:0] i_rx_slot;
  logic [19:0] i_rx_data;
  logic [6:0] flt;
  wire sck, cs_n, mosi, miso, miso_oe, send, mode, chan_en, mon_force, buffer_check_mode, disc, miso_w;
  wire [2:0] disc_cnt;
  int n_fail, cmp_count, cyc, n_send, n_bcm, n_disc, last_send, gap;
  assign miso_w = miso_oe ? miso : 1'bz;
  chan_ctrl #(.AUTO_PERIOD_CYC(AUTO_CYC)) dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_sck(sck), .i_cs_n(cs_n),
    .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe), .i_rx_valid(i_rx_valid),
    .i_rx_slot(i_rx_slot), .i_rx_data(i_rx_data), .i_rx_fault(i_rx_fault),
    .i_chan_cond(i_chan_cond), .i_disc_cond(i_disc_cond), .i_pll_unlock(flt[6]),
    .i_ref_clk_bad(flt[5]), .i_agnd_open(flt[4]), .i_dgnd_open(flt[3]),
    .i_overcurrent(flt[2]), .i_thermal(flt[1]), .i_supply_low(flt[0]),
    .o_broadcast_send(send), .o_collect_mode(mode), .o_chan_en(chan_en),
    .o_monitor_force(mon_force), .o_bcm_enter(buffer_check_mode), .o_disc_start(disc),
    .o_disc_count(disc_cnt));
  host_spi_model host_u (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso_w));
  always @(posedge i_clk) begin
    cyc++;
    n_bcm += (buffer_check_mode === 1'b1);
    n_disc += (disc === 1'b1);
    if (send === 1'b1) begin
      n_send++;
      gap = cyc - last_send;
      last_send = cyc;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    logic [23:0] r;
    host_u.xfer({1'b1, a}, d, r);
  endtask
  task automatic rd(input logic [6:0] a, output logic [23:0] r);
    host_u.xfer({1'b0, a}, 24'h0, r);
  endtask
  task automatic wait_send(input int n, input int lim);
    for (int k = 0; k < lim && n_send < n; k++) tick(1);
    `CHK(n_send >= n, 1'b1)
  endtask
  task automatic t_reset_vals();
    logic [23:0] r;
    logic [6:0] ofs [8] = '{7'h02, 7'h04, 7'h06, 7'h08, 7'h0a, 7'h0b, 7'h0e, 7'h30};
    foreach (ofs[i]) begin
      rd(ofs[i], r);
      `CHK(r, 24'h0)
    end
  endtask
  task automatic t_rx();
    logic [23:0] r;
    i_rx_slot = 2'd2;
    i_rx_data = 20'ha5c3e;
    i_rx_fault = 1'b1;
    i_rx_valid = 1'b1;
    tick(1);
    i_rx_slot = 2'd1;
    i_rx_data = 20'h30001;
    i_rx_fault = 1'b0;
    tick(1);
    i_ce = 1'b0;
    i_rx_slot = 2'd3;
    tick(2);
    i_rx_valid = 1'b0;
    i_ce = 1'b1;
    rd(7'h06, r);
    `CHK(r, 24'haa5c3e)
    rd(7'h06, r);
    `CHK(r, 24'h8a5c3e)
    rd(7'h04, r);
    `CHK(r, 24'h230001)
    rd(7'h08, r);
    `CHK(r, 24'h000000)
  endtask
  task automatic t_status();
    logic [23:0] r;
    flt = 7'h7f;
    tick(4);
    flt = 7'h00;
    rd(7'h0b, r);
    `CHK(r[7:0], 8'hfd)
    wr(7'h0b, 24'h0000ff);
    rd(7'h0b, r);
    `CHK(r[7:0], 8'hfd)
    wr(7'h0b, 24'h000000);
    rd(7'h0b, r);
    `CHK(r[7:0], 8'h00)
    flt = 7'h03;
    tick(4);
    rd(7'h02, r);
    `CHK(r[23:16], 8'h10)
    wr(7'h0b, 24'h000000);
    flt = 7'h00;
    rd(7'h0b, r);
    `CHK(r[7:0], 8'h05)
  endtask
  task automatic t_chan();
    logic [23:0] r;
    int b0, d0;
    i_chan_cond = 1'b0;
    wr(7'h0b, 24'h040000);
    `CHK(chan_en, 1'b0)
    i_chan_cond = 1'b1;
    wr(7'h0b, 24'h040000);
    `CHK(chan_en, 1'b1)
    rd(7'h0b, r);
    `CHK(r[23:16], 8'h04)
    b0 = n_bcm;
    d0 = n_disc;
    wr(7'h0b, 24'h030500);
    `CHK(n_bcm - b0, 1)
    `CHK(chan_en, 1'b1)
    `CHK(n_disc - d0, 0)
    wr(7'h0b, 24'h050300);
    `CHK(n_bcm - b0, 1)
    `CHK(n_disc - d0, 1)
    `CHK(disc_cnt, 3'd3)
    i_disc_cond = 1'b0;
    wr(7'h0b, 24'h040200);
    `CHK(n_disc - d0, 1)
    i_disc_cond = 1'b1;
    wr(7'h0b, 24'h080000);
    `CHK(mon_force, 1'b1)
    rd(7'h0b, r);
    `CHK(r[7:0], 8'h01)
    wr(7'h0b, 24'h000000);
    `CHK(mon_force, 1'b0)
  endtask
  task automatic t_collect();
    logic [23:0] r;
    int s0, t0, d;
    s0 = n_send;
    wr(7'h0a, 24'h010000);
    tick(10);
    `CHK(n_send - s0, 0)
    wr(7'h0a, 24'h020000);
    rd(7'h0a, r);
    `CHK(r, 24'h000000)
    wr(7'h0a, 24'h040400);
    `CHK(mode, 1'b1)
    wr(7'h0a, 24'h050400);
    t0 = cyc;
    wait_send(s0 + 1, 400);
    d = last_send - t0 + 10;
    `CHK(d >= 4 * STEP && d <= 4 * STEP + 10, 1'b1)
    wr(7'h0a, 24'h040900);
    rd(7'h0a, r);
    `CHK(r, 24'h040400)
    `CHK(n_send - s0, 1)
    wr(7'h0b, 24'h040000);
    `CHK(chan_en, 1'b0)
    wr(7'h0a, 24'h000000);
    `CHK(mode, 1'b1)
    wr(7'h0e, 24'hff0000);
    `CHK(mode, 1'b0)
    rd(7'h0a, r);
    `CHK(r, 24'h000000)
    wr(7'h0a, 24'h040000);
    wr(7'h0a, 24'h060000);
    s0 = n_send;
    wait_send(s0 + 2, 3 * AUTO_CYC);
    `CHK(gap, AUTO_CYC)
    wr(7'h0e, 24'hff0000);
    s0 = n_send;
    tick(2 * AUTO_CYC);
    `CHK(n_send - s0, 0)
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    {i_rst_n, i_rx_valid, i_rx_slot, i_rx_data, i_rx_fault, flt} = '0;
    {i_ce, i_chan_cond, i_disc_cond} = 3'b111;
    tick(5);
    i_rst_n = 1'b1;
    tick(6);
    t_reset_vals();
    t_rx();
    t_status();
    t_chan();
    t_collect();
    summarize();
  end
  initial begin
    #1000000;
    n_fail++;
    summarize();
  end
endmodule
